// ==== serial_rx_pkg.sv ====
// What this block does
// (R1) two-wire: SDA output waits four system clocks when hold setting is zero
// (R2) two-wire: nonzero hold setting delays SDA changes by that many clocks
// (R3) two-wire: a byte loaded during the hold after acknowledge sends all eight bits
// (R4) software picks only standard or four-line synchronous format, never two-line
// (R5) two-wire: received acknowledge sits at receive buffer bit 8
// (R6) two-wire: receive buffer bit 9 marks the first word of a frame
// (R7) synchronous: start-of-frame status bit marks each frame's first word
// (R8) synchronous and two-wire: first word alternate event, later words standard event
// (R9) audio: select sampled 1 gives alternate event, 0 gives standard event
// (R10) audio: sampled word select readable in protocol status
// (R11) asynchronous without parity: only the standard receive event is raised
// (R12) asynchronous with parity: argument bit holds parity, error bit holds check result
// (R13) synchronous with parity: argument bit holds parity, mismatch sets parity error flag
// (R14) two-wire: argument bit holds the received acknowledge for every word
// (R15) slave shift-clock output select would route transmit shift clock out
// (R16) shift-clock output select is absent: reads zero, writing one does nothing
package serial_rx_pkg;
  typedef enum logic [1:0] {MODE_ASYNC, MODE_SYNC, MODE_TWO_WIRE, MODE_AUDIO} mode_type;
  typedef enum logic [1:0] {FMT_STANDARD, FMT_DUAL, FMT_QUAD, FMT_RESERVED} format_type;
  localparam int DATA_BITS = 8;
  localparam int RX_WORD_BITS = 16;
  localparam int ACK_BIT_POS = 8;
  localparam int FIRST_BIT_POS = 9;
  localparam int FIFO_DEPTH_DEFAULT = 8;
  localparam int HOLD_WIDTH_DEFAULT = 4;
  localparam int HOLD_ZERO_CYCLES = 4;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic FIRST_RESET = 1'b1;
  typedef struct packed {
    logic [DATA_BITS-1:0] data;
    logic extra;
    logic first;
    logic wa;
  } rx_rec_type;
  typedef struct packed {
    logic sof;
    logic protocol_argument_bit;
    logic protocol_error_bit;
  } rx_status_type;
  typedef struct packed {
    logic word_address_select;
    logic parity_error_flag;
  } protocol_status_type;
endpackage

// ==== serial_rx.sv ====
module rx_word_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("fifo depth must be a power of two, at least 2");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic full;
  logic empty;
  assign empty = wr_ptr_reg == rd_ptr_reg;
  assign full = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) && (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem_reg[rd_ptr_reg[AW-1:0]];
  always_ff @(posedge clk_in) begin
    if (ce_in && in_valid_in && !full) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else if (ce_in) begin
      if (in_valid_in && !full) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (out_ready_in && !empty) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

module serial_rx import serial_rx_pkg::*; #(
  parameter int HOLD_WIDTH = HOLD_WIDTH_DEFAULT,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT
) (
  // system
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // link pins
  input wire logic link_clk_in,
  input wire logic frame_active_in,
  input wire logic serial_data_in,
  input wire logic word_address_select_in,
  input wire logic scl_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic shift_clock_output_out,
  // configuration
  input wire mode_type mode_in,
  input wire format_type format_in,
  input wire logic parity_en_in,
  input wire logic parity_odd_in,
  input wire logic [HOLD_WIDTH-1:0] sda_hold_delay_in,
  input wire logic shift_clock_out_select_in,
  // transmit buffer
  input wire logic tx_load_in,
  input wire logic [DATA_BITS-1:0] transmit_buffer_in,
  output logic tx_full_out,
  // receive buffer and status
  input wire logic rx_read_in,
  input wire logic status_clear_in,
  output logic [RX_WORD_BITS-1:0] receive_buffer_out,
  output logic rx_valid_out,
  output rx_status_type receive_buffer_status_out,
  output protocol_status_type protocol_status_out,
  output logic receive_event_flag_out,
  output logic alternate_receive_flag_out,
  output logic overrun_out,
  output logic format_error_out,
  output logic shift_clock_out_select_out
);
  if (HOLD_WIDTH < 3) begin : g_hold_check
    $error("hold width must hold the zero-setting count");
  end
  localparam logic [HOLD_WIDTH-1:0] HOLD_ZERO = HOLD_WIDTH'(HOLD_ZERO_CYCLES);

  // link domain: configuration is quasi-static, two-flop synchronised
  logic [2:0] cfg_l1_reg;
  logic [2:0] cfg_l2_reg;
  logic link_clr_n;
  logic [3:0] bit_cnt_reg;
  logic first_reg;
  logic [DATA_BITS-1:0] shift_reg;
  logic extra_reg;
  rx_rec_type rec_reg;
  logic rec_tog_reg;
  logic has_extra;
  logic word_done;
  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_l1_reg <= '0;
      cfg_l2_reg <= '0;
    end else begin
      cfg_l1_reg <= {mode_in, parity_en_in};
      cfg_l2_reg <= cfg_l1_reg;
    end
  end
  // two-wire always carries acknowledge; async and sync only with parity, audio never
  assign has_extra = (mode_type'(cfg_l2_reg[2:1]) == MODE_TWO_WIRE) ||
    (cfg_l2_reg[0] && mode_type'(cfg_l2_reg[2:1]) != MODE_AUDIO);
  assign word_done = bit_cnt_reg == (has_extra ? 4'h8 : 4'h7);
  // link clock stands between frames, so the frame level itself restarts counting
  assign link_clr_n = nrst_in & frame_active_in;
  always_ff @(posedge link_clk_in or negedge link_clr_n) begin
    if (!link_clr_n) begin
      bit_cnt_reg <= BIT_CNT_RESET;
      first_reg <= FIRST_RESET;
    end else if (word_done) begin
      bit_cnt_reg <= BIT_CNT_RESET;
      first_reg <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end
  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shift_reg <= '0;
      extra_reg <= 1'b0;
    end else if (bit_cnt_reg < 4'h8) begin
      shift_reg <= {shift_reg[DATA_BITS-2:0], serial_data_in};
    end else begin
      extra_reg <= serial_data_in;
    end
  end
  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rec_reg <= '0;
      rec_tog_reg <= 1'b0;
    end else if (word_done) begin
      rec_reg.data <= has_extra ? shift_reg : {shift_reg[DATA_BITS-2:0], serial_data_in};
      rec_reg.extra <= has_extra ? serial_data_in : 1'b0;
      rec_reg.first <= first_reg;
      rec_reg.wa <= word_address_select_in;
      rec_tog_reg <= !rec_tog_reg;
    end
  end

  // system domain: toggle crossing, record stays stable until picked up
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;
  logic push;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  rx_rec_type fifo_rec;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
    end else if (ce_in) begin
      tog_s1_reg <= rec_tog_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
    end
  end
  assign push = tog_s2_reg ^ tog_s3_reg;

  rx_word_fifo #(.WIDTH($bits(rx_rec_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .in_valid_in(push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(rec_reg),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(!rx_valid_out || rx_read_in),
    .out_data_out(fifo_rec)
  );
  assign fifo_pop = ce_in && fifo_out_valid && (!rx_valid_out || rx_read_in);

  // receive buffer load and status
  logic parity_bad;
  logic alt_event;
  assign parity_bad = (^fifo_rec.data) ^ fifo_rec.extra ^ parity_odd_in;
  always_comb begin
    case (mode_in)
      MODE_ASYNC: alt_event = 1'b0; // [R11]
      MODE_SYNC, MODE_TWO_WIRE: alt_event = fifo_rec.first; // [R8]
      MODE_AUDIO: alt_event = fifo_rec.wa; // [R9]
      default: alt_event = 1'b0;
    endcase
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      receive_buffer_out <= '0;
      receive_buffer_status_out <= '0;
      rx_valid_out <= 1'b0;
    end else if (ce_in) begin
      if (fifo_pop) begin
        rx_valid_out <= 1'b1;
        receive_buffer_out <= {8'h00, fifo_rec.data};
        if (mode_in == MODE_TWO_WIRE) begin
          receive_buffer_out[ACK_BIT_POS] <= fifo_rec.extra; // [R5]
          receive_buffer_out[FIRST_BIT_POS] <= fifo_rec.first; // [R6]
        end
        receive_buffer_status_out.sof <= fifo_rec.first &&
          (mode_in == MODE_SYNC || mode_in == MODE_TWO_WIRE); // [R7]
        receive_buffer_status_out.protocol_argument_bit <= fifo_rec.extra; // [R12] [R13] [R14]
        receive_buffer_status_out.protocol_error_bit <=
          mode_in == MODE_ASYNC && parity_en_in && parity_bad; // [R12]
      end else if (rx_read_in) begin
        rx_valid_out <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      receive_event_flag_out <= 1'b0;
      alternate_receive_flag_out <= 1'b0;
    end else if (ce_in) begin
      receive_event_flag_out <= fifo_pop && !alt_event; // [R8] [R9] [R11]
      alternate_receive_flag_out <= fifo_pop && alt_event; // [R8] [R9]
    end
  end
  // sticky flags: a new event in the clear cycle wins
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      protocol_status_out <= '0;
      overrun_out <= 1'b0;
    end else if (ce_in) begin
      if (fifo_pop && mode_in == MODE_AUDIO) begin
        protocol_status_out.word_address_select <= fifo_rec.wa; // [R10]
      end
      if (fifo_pop && mode_in == MODE_SYNC && parity_en_in && parity_bad) begin
        protocol_status_out.parity_error_flag <= 1'b1; // [R13]
      end else if (status_clear_in) begin
        protocol_status_out.parity_error_flag <= 1'b0;
      end
      if (push && !fifo_in_ready) begin
        overrun_out <= 1'b1;
      end else if (status_clear_in) begin
        overrun_out <= 1'b0;
      end
    end
  end
  // only the two-line format in synchronous mode raises a format error; reserved is not flagged
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      format_error_out <= 1'b0;
    end else if (ce_in) begin
      format_error_out <= mode_in == MODE_SYNC && format_in == FMT_DUAL; // [R4]
    end
  end
  // select bit not built: reads zero, the input is ignored
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shift_clock_out_select_out <= 1'b0;
      shift_clock_output_out <= 1'b0;
    end else if (ce_in) begin
      shift_clock_out_select_out <= 1'b0; // [R16]
      shift_clock_output_out <= 1'b0; // [R15] [R16]
    end
  end

  // two-wire transmit with SDA hold delay
  logic scl_s1_reg;
  logic scl_s2_reg;
  logic scl_s3_reg;
  logic scl_fall;
  logic [HOLD_WIDTH-1:0] hold_cnt_reg;
  logic hold_expire;
  logic [DATA_BITS-1:0] tx_shift_reg;
  logic [3:0] bits_left_reg;
  logic ack_slot_reg;
  logic [DATA_BITS-1:0] tx_buf_reg;
  logic tx_start;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
    end else if (ce_in) begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
    end
  end
  assign scl_fall = scl_s3_reg && !scl_s2_reg && mode_in == MODE_TWO_WIRE;
  assign hold_expire = ce_in && hold_cnt_reg == {{(HOLD_WIDTH-1){1'b0}}, 1'b1};
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_cnt_reg <= '0;
    end else if (ce_in) begin
      if (scl_fall) begin
        hold_cnt_reg <= (sda_hold_delay_in == '0) ? HOLD_ZERO : sda_hold_delay_in; // [R1] [R2]
      end else if (hold_cnt_reg != '0) begin
        hold_cnt_reg <= hold_cnt_reg - 1'b1;
      end
    end
  end
  // shifter takes the buffer at expiry, so a load inside the hold still starts at the msb
  assign tx_start = hold_expire && bits_left_reg == 4'h0 && !ack_slot_reg && tx_full_out;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_buf_reg <= '0;
      tx_full_out <= 1'b0;
    end else if (ce_in) begin
      if (tx_load_in && !tx_full_out) begin
        tx_buf_reg <= transmit_buffer_in;
        tx_full_out <= 1'b1;
      end else if (tx_start) begin
        tx_full_out <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_shift_reg <= '0;
      bits_left_reg <= 4'h0;
      ack_slot_reg <= 1'b0;
      sda_oe_out <= 1'b0;
      sda_out <= 1'b0;
    end else if (ce_in && hold_expire) begin
      if (tx_start) begin
        sda_oe_out <= !tx_buf_reg[DATA_BITS-1]; // [R3]
        tx_shift_reg <= {tx_buf_reg[DATA_BITS-2:0], 1'b0};
        bits_left_reg <= 4'h7; // [R3]
      end else if (bits_left_reg != 4'h0) begin
        sda_oe_out <= !tx_shift_reg[DATA_BITS-1];
        tx_shift_reg <= {tx_shift_reg[DATA_BITS-2:0], 1'b0};
        bits_left_reg <= bits_left_reg - 4'h1;
        ack_slot_reg <= bits_left_reg == 4'h1;
      end else begin
        sda_oe_out <= 1'b0;
        ack_slot_reg <= 1'b0;
      end
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  hold_zero_a: assert property ((scl_fall && ce_in && sda_hold_delay_in == '0) ##1 // [R1]
    (ce_in && !scl_fall)[*4] |-> hold_expire) else $error("zero hold not four clocks");
  hold_prog_a: assert property (scl_fall && ce_in && sda_hold_delay_in != '0 |=> // [R2]
    hold_cnt_reg == $past(sda_hold_delay_in)) else $error("hold count wrong");
  sda_timing_a: assert property ($changed(sda_oe_out) |-> $past(hold_expire)) // [R2]
    else $error("sda moved outside hold expiry");
  full_byte_a: assert property (tx_start |=> bits_left_reg == 4'h7 && !tx_full_out) // [R3]
    else $error("byte start lost a bit");
  ack_pos_a: assert property (fifo_pop && mode_in == MODE_TWO_WIRE |=> // [R5] [R14]
    receive_buffer_out[8] == $past(fifo_rec.extra) &&
    receive_buffer_status_out.protocol_argument_bit == receive_buffer_out[8])
    else $error("acknowledge misplaced");
  first_pos_a: assert property (fifo_pop && mode_in == MODE_TWO_WIRE |=> // [R6]
    receive_buffer_out[9] == $past(fifo_rec.first)) else $error("first mark wrong");
  sof_mark_a: assert property (fifo_pop && mode_in == MODE_SYNC |=> // [R7]
    receive_buffer_status_out.sof == $past(fifo_rec.first)) else $error("sof wrong");
  frame_event_a: assert property (fifo_pop && (mode_in == MODE_SYNC || // [R8]
    mode_in == MODE_TWO_WIRE) |=> alternate_receive_flag_out == $past(fifo_rec.first) &&
    receive_event_flag_out != alternate_receive_flag_out) else $error("event choice");
  audio_event_a: assert property (fifo_pop && mode_in == MODE_AUDIO |=> // [R9] [R10]
    alternate_receive_flag_out == $past(fifo_rec.wa) &&
    protocol_status_out.word_address_select == $past(fifo_rec.wa))
    else $error("audio select event");
  async_event_a: assert property (fifo_pop && mode_in == MODE_ASYNC |=> // [R11]
    receive_event_flag_out && !alternate_receive_flag_out) else $error("async alt");
  async_par_a: assert property (fifo_pop && mode_in == MODE_ASYNC && parity_en_in |=> // [R12]
    receive_buffer_status_out.protocol_error_bit == $past(parity_bad))
    else $error("async parity result");
  sync_par_a: assert property (fifo_pop && mode_in == MODE_SYNC && parity_en_in && // [R13]
    parity_bad |=> protocol_status_out.parity_error_flag) else $error("parity flag missed");
  sel_zero_a: assert property (shift_clock_out_select_in |=> // [R16]
    !shift_clock_out_select_out) else $error("select bit not zero");
endmodule

// ==== serial_peer.sv ====
module serial_peer (
  // link pins
  output logic link_clk_out,
  output logic frame_out,
  output logic data_out,
  output logic wa_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    link_clk_out = 1'b0;
    frame_out = 1'b0;
    data_out = 1'b0;
    wa_out = 1'b0;
  end
  // shift clock only runs while bits move, so the receiver cannot lean on a free clock
  task automatic send(input logic [8:0] bits, input int n, input logic wa);
    for (int i = n - 1; i >= 0; i--) begin
      data_out = bits[i];
      wa_out = wa;
      #24 link_clk_out = 1'b1;
      #24 link_clk_out = 1'b0;
    end
    // released line shows the inverse, never a stale copy of the last bit
    data_out = ~data_out;
  endtask
  task automatic frame(input logic on);
    #31 frame_out = on;
  endtask
endmodule

// ==== serial_rx_test.sv ====
`define CHK(what, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module serial_rx_test import serial_rx_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in;
  logic nrst_in;
  logic ce_in;
  logic link_clk, frame_act, ser_data, wa_sel;
  logic scl_in;
  logic sda_out, sda_oe_out, shift_clock_output_out;
  mode_type mode_in;
  format_type format_in;
  logic parity_en_in;
  logic parity_odd_in;
  logic [3:0] sda_hold_delay_in;
  logic shift_clock_out_select_in;
  logic tx_load_in;
  logic [7:0] transmit_buffer_in;
  logic tx_full_out;
  logic rx_read_in;
  logic status_clear_in;
  logic [15:0] receive_buffer_out;
  logic rx_valid_out;
  rx_status_type rstat;
  protocol_status_type pstat;
  logic receive_event_flag_out, alternate_receive_flag_out;
  logic overrun_out, format_error_out, shift_clock_out_select_out;
  int errors = 0;
  int n_tests = 0;
  int l0, l6;

  serial_peer peer (.link_clk_out(link_clk), .frame_out(frame_act), .data_out(ser_data),
    .wa_out(wa_sel));
  serial_rx #(.HOLD_WIDTH(4), .FIFO_DEPTH(8)) uut (.clk_in(clk_in), .nrst_in(nrst_in),
    .ce_in(ce_in), .link_clk_in(link_clk), .frame_active_in(frame_act),
    .serial_data_in(ser_data), .word_address_select_in(wa_sel), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .shift_clock_output_out(shift_clock_output_out),
    .mode_in(mode_in), .format_in(format_in), .parity_en_in(parity_en_in),
    .parity_odd_in(parity_odd_in), .sda_hold_delay_in(sda_hold_delay_in),
    .shift_clock_out_select_in(shift_clock_out_select_in), .tx_load_in(tx_load_in),
    .transmit_buffer_in(transmit_buffer_in), .tx_full_out(tx_full_out),
    .rx_read_in(rx_read_in), .status_clear_in(status_clear_in),
    .receive_buffer_out(receive_buffer_out), .rx_valid_out(rx_valid_out),
    .receive_buffer_status_out(rstat), .protocol_status_out(pstat),
    .receive_event_flag_out(receive_event_flag_out),
    .alternate_receive_flag_out(alternate_receive_flag_out), .overrun_out(overrun_out),
    .format_error_out(format_error_out), .shift_clock_out_select_out(shift_clock_out_select_out));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic rd(input logic [15:0] eb);
    `CHK("rx valid", 1'b1, rx_valid_out)
    `CHK("rx buffer", eb, receive_buffer_out)
    rx_read_in = 1'b1;
    @(negedge clk_in);
    rx_read_in = 1'b0;
    // let an edge pass so back-to-back reads never glitch the strobe
    @(negedge clk_in);
  endtask

  // one word across the link, then wait for its event under a bound
  task automatic word(input logic [8:0] bits, input int n, input logic wa, input logic [15:0] eb,
      input logic ea);
    int k;
    k = 0;
    peer.send(bits, n, wa);
    while (receive_event_flag_out !== 1'b1 && alternate_receive_flag_out !== 1'b1 && k < 20) begin
      @(negedge clk_in);
      k++;
    end
    `CHK("alt event", ea, alternate_receive_flag_out)
    `CHK("std event", !ea, receive_event_flag_out)
    rd(eb);
  endtask

  task automatic scl_cycle(input logic ld, input logic [7:0] b, output int lat);
    logic was;
    was = sda_oe_out;
    lat = -1;
    scl_in = 1'b0;
    for (int c = 1; c <= 16; c++) begin
      @(negedge clk_in);
      tx_load_in = ld && c == 3;
      transmit_buffer_in = b;
      if (lat < 0 && sda_oe_out !== was) lat = c;
    end
    scl_in = 1'b1;
    repeat (4) @(negedge clk_in);
  endtask

  // eight bits msb first as pulled-low levels, then the released acknowledge slot
  task automatic tx_byte(input logic [7:0] b, input logic ld, output int lat);
    int l;
    for (int i = 0; i <= 8; i++) begin
      scl_cycle(ld && i == 0, b, l);
      if (i == 0) lat = l;
      `CHK("sda pull", (i < 8) ? !b[7-i] : 1'b0, sda_oe_out)
    end
  endtask

  initial begin
    #300us;
    errors++;
    conclude();
  end

  initial begin
    nrst_in = 1'b0;
    ce_in = 1'b1;
    scl_in = 1'b1;
    mode_in = MODE_ASYNC;
    format_in = FMT_STANDARD;
    parity_en_in = 1'b0;
    parity_odd_in = 1'b0;
    sda_hold_delay_in = 4'h0;
    shift_clock_out_select_in = 1'b1;
    tx_load_in = 1'b0;
    transmit_buffer_in = 8'h00;
    rx_read_in = 1'b0;
    status_clear_in = 1'b0;
    repeat (3) @(negedge clk_in);
    nrst_in = 1'b1;
    @(negedge clk_in);
    `CHK("sclk out", 1'b0, shift_clock_output_out)
    `CHK("sclk select", 1'b0, shift_clock_out_select_out)
    peer.frame(1'b1);
    word({1'b0, 8'hA5}, 8, 1'b0, 16'h00A5, 1'b0);
    parity_en_in = 1'b1;
    word({8'h5A, 1'b1}, 9, 1'b0, 16'h005A, 1'b0);
    `CHK("arg bit", 1'b1, rstat.protocol_argument_bit)
    `CHK("err bit", 1'b1, rstat.protocol_error_bit)
    word({8'h5A, 1'b0}, 9, 1'b0, 16'h005A, 1'b0);
    `CHK("arg bit", 1'b0, rstat.protocol_argument_bit)
    `CHK("err bit", 1'b0, rstat.protocol_error_bit)
    parity_odd_in = 1'b1;
    word({8'h5A, 1'b1}, 9, 1'b0, 16'h005A, 1'b0);
    `CHK("odd err bit", 1'b0, rstat.protocol_error_bit)
    parity_odd_in = 1'b0;
    peer.frame(1'b0);
    @(negedge clk_in);
    mode_in = MODE_SYNC;
    format_in = FMT_QUAD;
    peer.frame(1'b1);
    word({8'h3C, 1'b0}, 9, 1'b0, 16'h003C, 1'b1);
    `CHK("sof", 1'b1, rstat.sof)
    `CHK("par flag", 1'b0, pstat.parity_error_flag)
    word({8'h3C, 1'b1}, 9, 1'b0, 16'h003C, 1'b0);
    `CHK("sof", 1'b0, rstat.sof)
    `CHK("arg bit", 1'b1, rstat.protocol_argument_bit)
    `CHK("par flag", 1'b1, pstat.parity_error_flag)
    status_clear_in = 1'b1;
    @(negedge clk_in);
    status_clear_in = 1'b0;
    @(negedge clk_in);
    `CHK("par flag", 1'b0, pstat.parity_error_flag)
    `CHK("fmt err", 1'b0, format_error_out)
    format_in = FMT_DUAL;
    repeat (3) @(negedge clk_in);
    `CHK("fmt err", 1'b1, format_error_out)
    format_in = FMT_STANDARD;
    peer.frame(1'b0);
    @(negedge clk_in);
    mode_in = MODE_TWO_WIRE;
    parity_en_in = 1'b0;
    peer.frame(1'b1);
    word({8'hC3, 1'b1}, 9, 1'b0, 16'h03C3, 1'b1);
    `CHK("ack arg", 1'b1, rstat.protocol_argument_bit)
    word({8'h81, 1'b0}, 9, 1'b0, 16'h0081, 1'b0);
    `CHK("ack arg", 1'b0, rstat.protocol_argument_bit)
    peer.frame(1'b0);
    @(negedge clk_in);
    mode_in = MODE_AUDIO;
    peer.frame(1'b1);
    word({1'b0, 8'h11}, 8, 1'b1, 16'h0011, 1'b1);
    `CHK("wa status", 1'b1, pstat.word_address_select)
    word({1'b0, 8'h22}, 8, 1'b0, 16'h0022, 1'b0);
    `CHK("wa status", 1'b0, pstat.word_address_select)
    peer.frame(1'b0);
    @(negedge clk_in);
    // buffer plus eight queued words fill up; the tenth must be dropped
    mode_in = MODE_ASYNC;
    peer.frame(1'b1);
    for (int i = 0; i < 10; i++) peer.send({1'b0, 8'hA0 + 8'(i)}, 8, 1'b0);
    peer.frame(1'b0);
    repeat (10) @(negedge clk_in);
    `CHK("overrun", 1'b1, overrun_out)
    // a read while frozen must leave the buffer alone
    ce_in = 1'b0;
    rx_read_in = 1'b1;
    @(negedge clk_in);
    rx_read_in = 1'b0;
    @(negedge clk_in);
    `CHK("frozen valid", 1'b1, rx_valid_out)
    `CHK("frozen buffer", 16'h00A0, receive_buffer_out)
    ce_in = 1'b1;
    for (int i = 0; i < 9; i++) rd({8'h00, 8'hA0 + 8'(i)});
    `CHK("drained", 1'b0, rx_valid_out)
    status_clear_in = 1'b1;
    @(negedge clk_in);
    status_clear_in = 1'b0;
    `CHK("overrun clear", 1'b0, overrun_out)
    mode_in = MODE_TWO_WIRE;
    transmit_buffer_in = 8'h7E;
    tx_load_in = 1'b1;
    @(negedge clk_in);
    tx_load_in = 1'b0;
    `CHK("tx full", 1'b1, tx_full_out)
    tx_byte(8'h7E, 1'b0, l0);
    `CHK("hold zero", 1'b1, l0 >= 5 && l0 <= 8)
    sda_hold_delay_in = 4'h6;
    tx_byte(8'h7E, 1'b1, l6);
    `CHK("hold step", 2, l6 - l0)
    `CHK("tx empty", 1'b0, tx_full_out)
    `CHK("sda level", 1'b0, sda_out)
    conclude();
  end
endmodule
